// [logic/boag_pkg.sv]
// Package with the register map, field layout and bus carrier of the bit operand address unit.
package boag_pkg;

  localparam int ADDR_W = 23;
  localparam int OFFS_W = 16;
  localparam int SIGN_EXT_W = 23;

  localparam logic [7:0] CTRL_OFFS      = 8'h00;
  localparam logic [7:0] POINTER_OFFS   = 8'h04;
  localparam logic [7:0] TEMP_OFFS      = 8'h08;
  localparam logic [7:0] AUX_ZERO_OFFS  = 8'h0C;
  localparam logic [7:0] BUF_START_OFFS = 8'h10;
  localparam logic [7:0] BIT_SRC_OFFS   = 8'h14;
  localparam logic [7:0] COMMAND_OFFS   = 8'h18;
  localparam logic [7:0] STATUS_OFFS    = 8'h1C;
  localparam logic [7:0] BIT_ADDR_OFFS  = 8'h20;

  localparam int CTRL_COMPAT_POS   = 0;
  localparam int CTRL_CIRC_POS     = 1;
  localparam int CMD_MODE_LSB      = 0;
  localparam int CMD_PAIR_POS      = 2;
  localparam int STAT_FLAG_ONE_POS = 0;
  localparam int STAT_FLAG_TWO_POS = 1;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_INDEXED     = 2'h0,
    MODE_BITREV_INC  = 2'h1,
    MODE_BITREV_DEC  = 2'h2,
    MODE_NONE        = 2'h3
  } boag_mode_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } boag_wb_req_s;

endpackage

// [logic/boag_bit_operand_address_gen.sv]
// Bit operand address generator with its Wishbone register slave.
//
// What this block does
// RL1 - Indexed operand with compat_mode_bit clear addresses pointer plus temp_offset_zero, plus buffer start when circular, and keeps the pointer.
// RL2 - Indexed operand with compat_mode_bit set uses ext_aux_reg_zero as the offset and still keeps the pointer.
// RL3 - A pair test loads the bit at the address into test_flag_one and the bit at address plus one into test_flag_two.
// RL4 - Bit-reversed increment addresses with the unmodified pointer, then adds the offset to the pointer with reverse carry.
// RL5 - Bit-reversed decrement addresses with the unmodified pointer, then subtracts the offset with reverse carry.
// RL6 - Software must not expect circular pointer behaviour from bit-reversed operands.
// RL7 - A circular pointer under a bit-reversed operand adds the sign-extended buffer start to the address and never wraps.
// RL8 - Reverse carry arithmetic runs its carries and borrows from the top bit toward the bottom bit.
`timescale 1ns/100ps

module boag_bit_operand_address_gen
  import boag_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire boag_wb_req_s       wbReq,
  output logic        [31:0]      wbDatO,
  output logic                    wbAckO,
  output logic                    testFlagOne,
  output logic                    testFlagTwo,
  output logic        [ADDR_W-1:0] bitAddress
);

  logic              compatMode;
  logic              circularMode;
  logic [ADDR_W-1:0] extAuxPointer;
  logic [OFFS_W-1:0] tempOffsetZero;
  logic [ADDR_W-1:0] extAuxRegZero;
  logic [OFFS_W-1:0] bufferStartValue;
  logic [31:0]       bitSource;
  logic [2:0]        lastCommand;

  logic              reqTaken;
  logic              wrTaken;
  logic              cmdWrite;
  boag_mode_e        cmdMode;
  logic              cmdPair;
  logic [ADDR_W-1:0] offsetValue;
  logic [ADDR_W-1:0] circBase;
  logic [ADDR_W-1:0] next_bitAddress;
  logic [ADDR_W-1:0] next_pointer;
  logic [31:0]       readWord;
  logic [31:0]       mergedWord;

  // Replaces the byte lanes picked by sel and leaves the others as they were.
  function automatic logic [31:0] laneMerge(input logic [31:0] oldVal, input logic [31:0] newVal,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Reverses the bit order of an address word.
  function automatic logic [ADDR_W-1:0] bitMirror(input logic [ADDR_W-1:0] v);
    logic [ADDR_W-1:0] res;
    res = '0;
    for (int i = 0; i < ADDR_W; i++) begin
      res[i] = v[ADDR_W-1-i];
    end
    return res;
  endfunction

  // Mirroring both operands turns an ordinary adder into one whose carries
  // run from the top bit downward, which is cheaper than a custom carry chain.
  function automatic logic [ADDR_W-1:0] reverseCarry(input logic [ADDR_W-1:0] a,
                                                     input logic [ADDR_W-1:0] b,
                                                     input logic subtract);
    logic [ADDR_W-1:0] sum;
    sum = subtract ? bitMirror(a) - bitMirror(b) : bitMirror(a) + bitMirror(b);
    return bitMirror(sum);
  endfunction

  // A request is taken only while ack is low, so each access is one transfer even
  // when the master is slow to release cyc and stb.
  assign reqTaken = wbReq.cyc && wbReq.stb && !wbAckO;
  assign wrTaken  = reqTaken && wbReq.we;
  assign cmdWrite = wrTaken && (wbReq.adr == COMMAND_OFFS) && wbReq.sel[0];
  // Command fields are decoded straight from the write data of the taken cycle.
  assign cmdMode  = boag_mode_e'(wbReq.dat[CMD_MODE_LSB +: 2]);
  assign cmdPair  = wbReq.dat[CMD_PAIR_POS];

  // Circular configuration only adds the sign-extended buffer start; the pointer
  // never wraps, because these operands cannot act as circular pointers.
  always_comb begin
    offsetValue = compatMode ? extAuxRegZero
                             : {{(ADDR_W-OFFS_W){tempOffsetZero[OFFS_W-1]}}, tempOffsetZero}; // [RL1] [RL2]
    circBase = circularMode
             ? {{(SIGN_EXT_W-OFFS_W){bufferStartValue[OFFS_W-1]}}, bufferStartValue}
             : '0; // [RL7]
    next_bitAddress = extAuxPointer + circBase;
    next_pointer    = extAuxPointer;
    unique case (cmdMode)
      MODE_INDEXED: begin
        next_bitAddress = extAuxPointer + circBase + offsetValue; // [RL1] [RL2]
      end
      MODE_BITREV_INC: begin
        next_pointer = reverseCarry(extAuxPointer, offsetValue, 1'b0); // [RL4] [RL8]
      end
      MODE_BITREV_DEC: begin
        next_pointer = reverseCarry(extAuxPointer, offsetValue, 1'b1); // [RL5] [RL8]
      end
      MODE_NONE: begin
        // No operand: the address shows the pointer plus circBase and the flags keep their value.
        next_pointer = extAuxPointer;
      end
    endcase
  end

  // Ack is registered, so every request costs one wait state; in exchange the
  // read multiplexer never sits on a combinational path back to the master.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wbAckO <= 1'b0;
    end else begin
      wbAckO <= reqTaken;
    end
  end

  // Unmapped offsets read as zero so that software can probe the map safely.
  always_comb begin
    unique case (wbReq.adr)
      CTRL_OFFS:      readWord = {30'h0000_0000, circularMode, compatMode};
      POINTER_OFFS:   readWord = {{(32-ADDR_W){1'b0}}, extAuxPointer};
      TEMP_OFFS:      readWord = {16'h0000, tempOffsetZero};
      AUX_ZERO_OFFS:  readWord = {{(32-ADDR_W){1'b0}}, extAuxRegZero};
      BUF_START_OFFS: readWord = {16'h0000, bufferStartValue};
      BIT_SRC_OFFS:   readWord = bitSource;
      COMMAND_OFFS:   readWord = {29'h0000_0000, lastCommand};
      STATUS_OFFS:    readWord = {30'h0000_0000, testFlagTwo, testFlagOne};
      BIT_ADDR_OFFS:  readWord = {{(32-ADDR_W){1'b0}}, bitAddress};
      default:        readWord = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wbDatO <= REG_RESET;
    end else if (reqTaken && !wbReq.we) begin
      wbDatO <= readWord;
    end
  end

  // Every writable register reads back zero-extended, so merging the write lanes into
  // the read word gives the new value of whichever register is addressed.
  always_comb begin
    mergedWord = laneMerge(readWord, wbReq.dat, wbReq.sel);
  end

  // Status and bit address are results only; writes to them fall into the default
  // branch and are dropped.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      compatMode       <= 1'b0;
      circularMode     <= 1'b0;
      tempOffsetZero   <= '0;
      extAuxRegZero    <= '0;
      bufferStartValue <= '0;
      bitSource        <= REG_RESET;
    end else if (wrTaken) begin
      unique case (wbReq.adr)
        CTRL_OFFS: begin
          if (wbReq.sel[0]) begin
            compatMode   <= wbReq.dat[CTRL_COMPAT_POS];
            circularMode <= wbReq.dat[CTRL_CIRC_POS];
          end
        end
        TEMP_OFFS: begin
          tempOffsetZero <= mergedWord[OFFS_W-1:0];
        end
        AUX_ZERO_OFFS: begin
          extAuxRegZero <= mergedWord[ADDR_W-1:0];
        end
        BUF_START_OFFS: begin
          bufferStartValue <= mergedWord[OFFS_W-1:0];
        end
        BIT_SRC_OFFS: begin
          bitSource <= mergedWord;
        end
        default: begin
        end
      endcase
    end
  end

  // A command write uses the pointer value from before any update, so a
  // bit-reversed operand addresses with the unmodified pointer.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      extAuxPointer <= '0;
    end else if (cmdWrite) begin
      extAuxPointer <= next_pointer; // [RL4] [RL5] [RL7]
    end else if (wrTaken && wbReq.adr == POINTER_OFFS) begin
      extAuxPointer <= mergedWord[ADDR_W-1:0];
    end
  end

  // The source word holds 32 bits, so only the low five address bits pick a bit.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bitAddress  <= '0;
      testFlagOne <= 1'b0;
      testFlagTwo <= 1'b0;
      lastCommand <= 3'h0;
    end else if (cmdWrite) begin
      bitAddress  <= next_bitAddress;
      lastCommand <= {cmdPair, cmdMode};
      if (cmdPair && cmdMode != MODE_NONE) begin
        testFlagOne <= bitSource[next_bitAddress[4:0]]; // [RL3]
        // The second bit wraps from 31 to 0, as the five-bit index does.
        testFlagTwo <= bitSource[5'(next_bitAddress[4:0] + 5'h01)]; // [RL3]
      end
    end
  end

endmodule

// [test/boag_properties.sv]
// Checker of bus handshake and result registers of the bit operand address unit.
`timescale 1ns/100ps
module boag_properties
  import boag_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              srst,
  input wire boag_wb_req_s      wbReq,
  input wire logic [31:0]       wbDatO,
  input wire logic              wbAckO,
  input wire logic              testFlagOne,
  input wire logic              testFlagTwo,
  input wire logic [ADDR_W-1:0] bitAddress
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic cmdWr;
  assign cmdWr = wbReq.cyc && wbReq.stb && !wbAckO && wbReq.we && wbReq.adr == COMMAND_OFFS
                 && wbReq.sel[0];
  sequence s_take; wbReq.cyc && wbReq.stb && !wbAckO; endsequence
  sequence s_rd(a); s_take ##0 !wbReq.we && wbReq.adr == a; endsequence
  property p_ackNext; s_take |=> wbAckO; endproperty
  property p_ackPulse; wbAckO |=> !wbAckO; endproperty
  property p_ackCause; wbAckO |-> $past(wbReq.cyc && wbReq.stb); endproperty
  property p_addrHold; !cmdWr |=> $stable(bitAddress); endproperty
  property p_flagHold; !cmdWr |=> $stable({testFlagTwo, testFlagOne}); endproperty
  property p_statRead; s_rd(STATUS_OFFS) |=> wbDatO == {30'h0, testFlagTwo, testFlagOne};
  endproperty
  property p_addrRead; s_rd(BIT_ADDR_OFFS) |=> wbDatO == {9'h0, bitAddress}; endproperty
  property p_unmapped; s_take ##0 !wbReq.we && wbReq.adr > BIT_ADDR_OFFS |=> wbDatO == '0;
  endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack late");
  a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
  a_ackCause: assert property (p_ackCause) else $error("ack without request");
  a_addrHold: assert property (p_addrHold) else $error("address moved");
  a_flagHold: assert property (p_flagHold) else $error("flags moved");
  a_statRead: assert property (p_statRead) else $error("status read wrong");
  a_addrRead: assert property (p_addrRead) else $error("address read wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind boag_bit_operand_address_gen boag_properties chk_u (.ref_clk(ref_clk), .srst(srst),
  .wbReq(wbReq), .wbDatO(wbDatO), .wbAckO(wbAckO), .testFlagOne(testFlagOne),
  .testFlagTwo(testFlagTwo), .bitAddress(bitAddress));

// [test/boag_tb.sv]
// Self-checking bench of the bit operand address unit.
`timescale 1ns/100ps
module testbench
  import boag_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              srst = 1'b1;
  boag_wb_req_s      wbReq = '0;
  logic [31:0]       wbDatO, lfsr = 32'h5E95, src, exq[$], cmq[$];
  logic              wbAckO, testFlagOne, testFlagTwo, f1, f2, pair;
  logic [ADDR_W-1:0] bitAddress, ptr, adr, off, bs, aux;
  logic [15:0]       tmp, bsv;
  logic [1:0]        ctl, mode;
  int                fails = 0, compares = 0;
  always #4 ref_clk = ~ref_clk;
  boag_bit_operand_address_gen dut_u (.ref_clk(ref_clk), .srst(srst), .wbReq(wbReq),
    .wbDatO(wbDatO), .wbAckO(wbAckO), .testFlagOne(testFlagOne),
    .testFlagTwo(testFlagTwo), .bitAddress(bitAddress));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    for (int k = 0; k < 32; k++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    return x;
  endfunction
  // Carries ripple from the top bit down; a borrow is a carry of the inverted
  // subtrahend with a carry of one into the top bit.
  function automatic logic [22:0] rc(input logic [22:0] a, b, input logic sub);
    logic [22:0] r;
    logic        c, bk;
    c = sub;
    r = '0;
    for (int k = 22; k >= 0; k--) begin
      bk = b[k] ^ sub;
      r[k] = a[k] ^ bk ^ c;
      c = (a[k] & bk) | (c & (a[k] ^ bk));
    end
    return r;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    wbReq <= '{1'b1, 1'b1, we, a, s, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAckO !== 1'b1 && n < 50);
    if (wbAckO !== 1'b1) fails++;
    wbReq <= '0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  always @(posedge ref_clk)
    if (wbAckO === 1'b1 && wbReq.we === 1'b0 && exq.size() > 0) check(wbDatO, exq.pop_front());
  always @(posedge ref_clk)
    if (wbAckO === 1'b1 && wbReq.we === 1'b1 && wbReq.adr === COMMAND_OFFS && cmq.size() > 0)
      check({7'h0, testFlagTwo, testFlagOne, bitAddress}, cmq.pop_front());
  task automatic conclude();
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(POINTER_OFFS, 32'h0);
    rd(BIT_ADDR_OFFS, 32'h0);
    xfer(1'b1, STATUS_OFFS, 32'h3);
    rd(STATUS_OFFS, 32'h0);
    xfer(1'b1, 8'h24, 32'h1);
    rd(8'h24, 32'h0);
    $display("Reset and access test done");
    f1 = 1'b0;
    f2 = 1'b0;
    for (int i = 0; i < 60; i++) begin
      lfsr = nxt(lfsr);
      {bsv, tmp} = lfsr;
      lfsr = nxt(lfsr);
      {pair, ctl, aux} = lfsr[25:0];
      mode = 2'(i % 4);
      lfsr = nxt(lfsr);
      src = lfsr;
      lfsr = nxt(lfsr);
      ptr = lfsr[22:0];
      xfer(1'b1, TEMP_OFFS, {16'h0, tmp});
      xfer(1'b1, BUF_START_OFFS, {16'h0, bsv});
      xfer(1'b1, AUX_ZERO_OFFS, {9'h0, aux});
      xfer(1'b1, CTRL_OFFS, {30'h0, ctl});
      xfer(1'b1, BIT_SRC_OFFS, src);
      xfer(1'b1, POINTER_OFFS, {9'h0, ptr});
      off = ctl[0] ? aux : {{7{tmp[15]}}, tmp};
      bs = ctl[1] ? {{7{bsv[15]}}, bsv} : '0;
      adr = ptr + bs + (mode == MODE_INDEXED ? off : '0);
      if (mode == MODE_BITREV_INC || mode == MODE_BITREV_DEC)
        ptr = rc(ptr, off, mode == MODE_BITREV_DEC);
      if (pair && mode != MODE_NONE) {f2, f1} = {src[adr[4:0] + 5'h1], src[adr[4:0]]};
      cmq.push_back({7'h0, f2, f1, adr});
      xfer(1'b1, COMMAND_OFFS, {29'h0, pair, mode});
      rd(COMMAND_OFFS, {29'h0, pair, mode});
      rd(BIT_ADDR_OFFS, {9'h0, adr});
      rd(POINTER_OFFS, {9'h0, ptr});
      rd(STATUS_OFFS, {30'h0, f2, f1});
    end
    $display("Operand form test done");
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(POINTER_OFFS, 32'h0);
    rd(STATUS_OFFS, 32'h0);
    rd(BIT_ADDR_OFFS, 32'h0);
    rd(CTRL_OFFS, 32'h0);
    xfer(1'b1, POINTER_OFFS, 32'h00FF_FFFF, 4'h1);
    rd(POINTER_OFFS, 32'h0000_00FF);
    xfer(1'b1, CTRL_OFFS, 32'h3, 4'hE);
    rd(CTRL_OFFS, 32'h0);
    $display("Mid-run reset and lane test done");
    conclude();
  end
endmodule
